// ==== hw/acd_adc_ctrl.v ====
// ADC setup register, settling timer, conversion start and result register
`timescale 1ns/1ns
`default_nettype none
`include "acd_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// [RULE_01] With auto mode off, convert only on a software write to the trigger register.
// [RULE_02] With auto mode on, start a conversion when the 16 us settling period ends.
// [RULE_03] A setup write applies channel and gain; gain codes 0..3 mean x1, x2, x4, x8.
// [RULE_04] Codes 0..15 pick channels 1..16; upper codes pick 17..32, or ground if differential.
// [RULE_05] Setup writes are ignored while the settling period is still running.
// [RULE_06] Host uses only 16 or 32 bit transfers on the setup register.
// [RULE_07] Host never writes the setup register while the sequencer runs.
// [RULE_08] Conversion and settling interrupts appear only with the global enable set.
// [RULE_09] Result holds the sample as 16-bit two's complement in bits 15:0, read-only.
// [RULE_10] Result bits 31:16 read zero and writes to them do nothing.
// [RULE_11] Result loads when the busy flag falls after a trigger or auto conversion.
// [RULE_12] Sequencer conversions leave the result register unchanged.
// [RULE_13] Full scale or overrange reads 7fff, negative full scale or underrange 8000.
// [RULE_14] Software discards the first two conversions after power-up.
// [RULE_15] Every accepted setup write sets settling active until the settling time ends.
// [RULE_16] In auto mode the busy flag sets by itself once settling has elapsed.
// [RULE_17] In manual mode any write of any value to the trigger register converts; the code ignores trigger writes while seq_mode_i is set.
// [RULE_18] Setup fields hold the last accepted write; reset clears them to zero.
module acd_adc_ctrl (
   input wire mclk_i,               // Local bus clock
   input wire rst_n_i,              // Synchronous reset, active low
   input wire [8:0] bus_addr_i,     // Register byte address
   input wire bus_wr_i,             // Write strobe, one cycle
   input wire bus_rd_i,             // Read strobe, one cycle
   input wire [3:0] bus_be_i,       // Byte enables, bit 0 is data 7:0
   input wire [31:0] bus_wdata_i,   // Write data
   output reg [31:0] bus_rdata_o,   // Read data, valid cycle after read strobe
   input wire seq_mode_i,           // Sequencer selected
   input wire seq_conv_i,           // Sequencer owns the running conversion
   input wire global_irq_enable_i,  // Master interrupt enable
   input wire adc_busy_i,           // Converter busy pin
   input wire [15:0] adc_sample_i,  // Converter sample, two's complement
   input wire adc_over_i,           // Converter overrange indication
   input wire adc_under_i,          // Converter underrange indication
   output reg adc_start_o,          // Conversion start pulse
   output reg adc_reset_o,          // Converter reset level
   output reg [1:0] gain_o,         // Amplifier gain code
   output reg [4:0] chan_o,         // Multiplexer channel code
   output reg input_pairing_sel_o,  // Differential input selected
   output reg ground_sel_o,         // Converter input tied to ground
   output wire settling_active_o,   // Settling time running
   output wire conv_busy_o,         // Conversion in progress
   output reg irq_settle_o,         // Settling done interrupt pulse
   output reg irq_conv_o            // Conversion done interrupt pulse
);

////////////////////////////////////////////////////////////////////////////////
reg [`ACD_SETUP_W-1:0] setup_r;
reg [`ACD_CNT_W-1:0] settle_cnt_r;
reg settling_r;
reg conv_busy_r;
reg own_conv_r;
reg [15:0] result_r;
reg busy_s1_r;
reg busy_s2_r;
reg busy_s3_r;
wire setup_hit;
wire trig_hit;
wire setup_wr;
wire settle_end;
wire manual_start;
wire auto_start;
wire busy_fall;
reg [15:0] sample_code;

assign setup_hit = bus_wr_i && (bus_addr_i == `ACD_OFS_SETUP) && ((bus_be_i & `ACD_BE_HALF) == `ACD_BE_HALF);
assign trig_hit = bus_wr_i && (bus_addr_i == `ACD_OFS_TRIGGER);
assign setup_wr = setup_hit && !settling_r; // [RULE_05]
assign settle_end = settling_r && (settle_cnt_r == `ACD_CNT_W'd1);
assign manual_start = trig_hit && !setup_r[`ACD_BIT_AUTO] && !seq_mode_i; // [RULE_01] [RULE_17]
assign auto_start = settle_end && setup_r[`ACD_BIT_AUTO]; // [RULE_02] [RULE_16]
assign busy_fall = busy_s3_r && !busy_s2_r;
assign settling_active_o = settling_r;
assign conv_busy_o = conv_busy_r;

////////////////////////////////////////////////////////////////////////////////
// Setup register
always @(posedge mclk_i) begin
   if (!rst_n_i) begin
      setup_r <= `ACD_SETUP_RST; // [RULE_18]
   end else if (setup_wr) begin
      setup_r <= bus_wdata_i[`ACD_SETUP_W-1:0]; // [RULE_03] [RULE_18]
   end
end

// Multiplexer and amplifier drive
always @(posedge mclk_i) begin
   if (!rst_n_i) begin
      gain_o <= 2'h0;
      chan_o <= 5'h00;
      input_pairing_sel_o <= 1'b0;
      ground_sel_o <= 1'b0;
      adc_reset_o <= 1'b0;
   end else begin
      gain_o <= setup_r[`ACD_GAIN_HI:`ACD_GAIN_LO]; // [RULE_03]
      chan_o <= setup_r[`ACD_CHAN_HI:`ACD_CHAN_LO]; // [RULE_04]
      input_pairing_sel_o <= setup_r[`ACD_BIT_DIFF];
      ground_sel_o <= setup_r[`ACD_BIT_DIFF] && setup_r[`ACD_BIT_CHAN_UPPER]; // [RULE_04]
      adc_reset_o <= setup_r[`ACD_BIT_RST];
   end
end

////////////////////////////////////////////////////////////////////////////////
// Settling timer
always @(posedge mclk_i) begin
   if (!rst_n_i) begin
      settling_r <= 1'b0;
      settle_cnt_r <= {`ACD_CNT_W{1'b0}};
   end else if (setup_wr) begin
      settling_r <= 1'b1; // [RULE_15]
      settle_cnt_r <= `ACD_SETTLE_CYC;
   end else if (settle_end) begin
      settling_r <= 1'b0; // [RULE_15]
      settle_cnt_r <= {`ACD_CNT_W{1'b0}};
   end else if (settling_r) begin
      settle_cnt_r <= settle_cnt_r - `ACD_CNT_W'd1;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Busy pin synchroniser; third stage only for edge detection
always @(posedge mclk_i) begin
   if (!rst_n_i) begin
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
      busy_s3_r <= 1'b0;
   end else begin
      busy_s1_r <= adc_busy_i;
      busy_s2_r <= busy_s1_r;
      busy_s3_r <= busy_s2_r;
   end
end

// Conversion start and busy tracking
always @(posedge mclk_i) begin
   if (!rst_n_i) begin
      adc_start_o <= 1'b0;
      conv_busy_r <= 1'b0;
      own_conv_r <= 1'b0;
   end else begin
      adc_start_o <= manual_start || auto_start;
      if (manual_start || auto_start) begin
         conv_busy_r <= 1'b1; // [RULE_16]
         own_conv_r <= !seq_conv_i;
      end else if (busy_fall) begin
         conv_busy_r <= 1'b0;
         own_conv_r <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Result coding and register
always @* begin
   sample_code = adc_sample_i;
   if (adc_over_i) begin
      sample_code = `ACD_POS_FULL; // [RULE_13]
   end else if (adc_under_i) begin
      sample_code = `ACD_NEG_FULL; // [RULE_13]
   end
end

always @(posedge mclk_i) begin
   if (!rst_n_i) begin
      result_r <= `ACD_ZERO16;
   end else if (busy_fall && conv_busy_r && own_conv_r && !seq_conv_i) begin
      result_r <= sample_code; // [RULE_09] [RULE_11] [RULE_12]
   end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt pulses
always @(posedge mclk_i) begin
   if (!rst_n_i) begin
      irq_settle_o <= 1'b0;
      irq_conv_o <= 1'b0;
   end else begin
      irq_settle_o <= settle_end && setup_r[`ACD_BIT_IRQ_SETTLE] && global_irq_enable_i; // [RULE_08]
      irq_conv_o <= busy_fall && conv_busy_r && setup_r[`ACD_BIT_IRQ_CONV] && global_irq_enable_i; // [RULE_08]
   end
end

////////////////////////////////////////////////////////////////////////////////
// Read path
always @(posedge mclk_i) begin
   if (!rst_n_i) begin
      bus_rdata_o <= `ACD_ZERO32;
   end else if (bus_rd_i) begin
      case (bus_addr_i)
         `ACD_OFS_SETUP: bus_rdata_o <= {20'h00000, setup_r};
         `ACD_OFS_RESULT: bus_rdata_o <= {16'h0000, result_r}; // [RULE_10]
         `ACD_OFS_FLAGS: bus_rdata_o <= {30'h0, settling_r, conv_busy_r};
         default: bus_rdata_o <= `ACD_ZERO32;
      endcase
   end
end

endmodule
`default_nettype wire

// ==== hw/acd_defs.vh ====
// Constants for the ADC control and data register block
`ifndef ACD_DEFS_VH
`define ACD_DEFS_VH
`define ACD_OFS_SETUP 9'h000
`define ACD_OFS_RESULT 9'h004
`define ACD_OFS_FLAGS 9'h008
`define ACD_OFS_TRIGGER 9'h00c
`define ACD_BIT_RST 11
`define ACD_BIT_IRQ_CONV 10
`define ACD_BIT_IRQ_SETTLE 9
`define ACD_BIT_AUTO 8
`define ACD_GAIN_HI 7
`define ACD_GAIN_LO 6
`define ACD_BIT_DIFF 5
`define ACD_CHAN_HI 4
`define ACD_CHAN_LO 0
`define ACD_BIT_CHAN_UPPER 4
`define ACD_SETUP_W 12
`define ACD_SETUP_RST 12'h000
`define ACD_BE_HALF 4'h3
`define ACD_CLK_MHZ 20
`define ACD_SETTLE_US 16
// Settling span in clocks: 16 us at 20 MHz, sized to the counter
`define ACD_SETTLE_CYC 9'd320
`define ACD_CNT_W 9
`define ACD_POS_FULL 16'h7fff
`define ACD_NEG_FULL 16'h8000
`define ACD_ZERO16 16'h0000
`define ACD_ZERO32 32'h00000000
`endif

// ==== tb/acd_adc_model.sv ====
// Converter model: busy pulse after start, sample goes stale after busy falls
`timescale 1ns/1ns
`default_nettype none
module acd_adc_model(
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic [3:0] lat_i,
   input wire logic [15:0] val_i,
   output logic busy_o,
   output logic [15:0] sample_o
);
   initial begin
      busy_o = 1'b0;
      sample_o = 16'h0000;
   end
   always begin
      @(posedge clk_i);
      if (start_i) begin
         repeat (lat_i) @(posedge clk_i);
         busy_o <= 1'b1;
         sample_o <= ~val_i;
         repeat (lat_i + 8) @(posedge clk_i);
         sample_o <= val_i;
         @(posedge clk_i);
         busy_o <= 1'b0;
         repeat (5) @(posedge clk_i);
         sample_o <= ~val_i;
      end
   end
endmodule
`default_nettype wire

// ==== tb/acd_properties.sv ====
// Checker for the ADC control and result register block
`timescale 1ns/1ns
`default_nettype none
module acd_props(
   input wire logic mclk_i, rst_n_i, bus_wr_i, bus_rd_i, seq_mode_i, global_irq_enable_i,
   input wire logic [8:0] bus_addr_i,
   input wire logic [3:0] bus_be_i,
   input wire logic [31:0] bus_wdata_i, bus_rdata_o,
   input wire logic adc_start_o, input_pairing_sel_o, ground_sel_o, settling_active_o, conv_busy_o,
   input wire logic irq_settle_o, irq_conv_o, adc_reset_o,
   input wire logic [1:0] gain_o,
   input wire logic [4:0] chan_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   wire acc = bus_wr_i && bus_addr_i == 9'h000 && bus_be_i[1:0] == 2'h3 && !settling_active_o;
   wire trg = bus_wr_i && bus_addr_i == 9'h00c;
   logic [11:0] cfg_r;
   wire auto_r = cfg_r[8];
   always @(posedge mclk_i)
      if (!rst_n_i) cfg_r <= 12'h000;
      else if (acc) cfg_r <= bus_wdata_i[11:0];
   ////////////////////////////////////////////////////////////////////////////////
   property p_trig; trg && !auto_r && !seq_mode_i |=> adc_start_o && conv_busy_o; endproperty
   a_trig: assert property (p_trig) else $error("trigger write gave no start");
   property p_manual; adc_start_o |-> $past(trg) || (auto_r && $fell(settling_active_o)); endproperty
   a_manual: assert property (p_manual) else $error("start without cause");
   property p_auto; auto_r && $fell(settling_active_o) |-> adc_start_o && conv_busy_o; endproperty
   a_auto: assert property (p_auto) else $error("no auto start");
   property p_settle; acc |-> ##[320:320] settling_active_o ##1 !settling_active_o; endproperty
   a_settle: assert property (p_settle) else $error("settling span wrong");
   property p_ignore;
      settling_active_o && bus_wr_i && bus_addr_i == 9'h000 |-> ##2 $stable({gain_o, chan_o, input_pairing_sel_o});
   endproperty
   a_ignore: assert property (p_ignore) else $error("write taken while settling");
   property p_field;
      acc |-> ##2 gain_o == $past(bus_wdata_i[7:6], 2) && chan_o == $past(bus_wdata_i[4:0], 2)
         && input_pairing_sel_o == $past(bus_wdata_i[5], 2);
   endproperty
   a_field: assert property (p_field) else $error("setup fields wrong");
   property p_gnd; ground_sel_o == (input_pairing_sel_o && chan_o[4]); endproperty
   a_gnd: assert property (p_gnd) else $error("ground select wrong");
   property p_hi; bus_rd_i && bus_addr_i == 9'h004 |=> bus_rdata_o[31:16] == 16'h0000; endproperty
   a_hi: assert property (p_hi) else $error("result upper half not zero");
   property p_irq; irq_conv_o || irq_settle_o |-> $past(global_irq_enable_i); endproperty
   a_irq: assert property (p_irq) else $error("interrupt without enable");
   property p_irq_st; $fell(settling_active_o) && cfg_r[9] && $past(global_irq_enable_i) |-> irq_settle_o; endproperty
   a_irq_st: assert property (p_irq_st) else $error("settling interrupt missing");
   property p_irq_cv; $fell(conv_busy_o) && cfg_r[10] && $past(global_irq_enable_i) |-> irq_conv_o; endproperty
   a_irq_cv: assert property (p_irq_cv) else $error("conversion interrupt missing");
   property p_rst; acc |-> ##2 adc_reset_o == $past(bus_wdata_i[11], 2); endproperty
   a_rst: assert property (p_rst) else $error("converter reset bit wrong");
   c_auto: cover property (auto_r && adc_start_o);
   c_irq: cover property (irq_conv_o);
   c_ref: cover property (settling_active_o && bus_wr_i && bus_addr_i == 9'h000);
endmodule
bind acd_adc_ctrl acd_props acd_props_i (.*);
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the ADC control and result register block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, sconv = 1'b0, global_irq_enable = 1'b0, ovr = 1'b0, und = 1'b0;
   logic [8:0] addr = 9'h000;
   logic [3:0] be = 4'hf, lat = 4'h1;
   logic [31:0] wd = 32'h0, rdata;
   logic [15:0] val = 16'h0, samp, rnd = 16'h0012;
   logic start, busy, settle, cbusy, rd_d = 1'b0, smode = 1'b0;
   int bad_count = 0, checks = 0;
   logic [31:0] q[$];
   initial forever #25 mclk_i = ~mclk_i;
   acd_adc_ctrl acd_adc_ctrl_i(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_addr_i(addr), .bus_wr_i(wr), .bus_rd_i(rd),
      .bus_be_i(be), .bus_wdata_i(wd), .bus_rdata_o(rdata), .seq_mode_i(smode), .seq_conv_i(sconv),
      .global_irq_enable_i(global_irq_enable), .adc_busy_i(busy), .adc_sample_i(samp), .adc_over_i(ovr), .adc_under_i(und),
      .adc_start_o(start), .adc_reset_o(), .gain_o(), .chan_o(), .input_pairing_sel_o(), .ground_sel_o(),
      .settling_active_o(settle), .conv_busy_o(cbusy), .irq_settle_o(), .irq_conv_o());
   acd_adc_model acd_adc_model_i(.clk_i(mclk_i), .start_i(start), .lat_i(lat), .val_i(val), .busy_o(busy),
      .sample_o(samp));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task acc(input logic w, input logic [8:0] a, input logic [3:0] b, input logic [31:0] d);
      @(posedge mclk_i);
      wr <= w;
      rd <= !w;
      addr <= a;
      be <= b;
      wd <= d;
      @(posedge mclk_i);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task rdx(input logic [8:0] a, input logic [31:0] e);
      q.push_back(e);
      acc(1'b0, a, 4'hf, 32'h0);
   endtask
   task idle;
      int n;
      n = 0;
      do @(posedge mclk_i); while ((settle || cbusy) && ++n < 2000);
      if (n >= 2000) bad_count++;
   endtask
   always @(posedge mclk_i) begin
      if (rd_d) chk(rdata, q.pop_front());
      rd_d <= rd;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic [15:0] e;
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rdx(9'h004, 0);
      rdx(9'h000, 0);
      rdx(9'h1f0, 0);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         d = {24'h0, i[1:0], rnd[5:0]};
         acc(1'b1, 9'h000, i[0] ? 4'h3 : 4'hf, d);
         acc(1'b1, 9'h000, 4'hf, ~d);
         rdx(9'h000, d);
         idle;
      end
      acc(1'b1, 9'h000, 4'h1, 32'h80);
      rdx(9'h000, d);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         val <= rnd;
         lat <= rnd[3:0];
         ovr <= i == 1;
         und <= i == 2;
         sconv <= i == 3;
         e = i == 1 ? 16'h7fff : i == 2 ? 16'h8000 : i == 3 ? e : rnd;
         acc(1'b1, 9'h00c, 4'hf, {rnd, rnd});
         idle;
         acc(1'b1, 9'h004, 4'hf, 32'hffffffff);
         rdx(9'h004, {16'h0, e});
      end
      global_irq_enable <= 1'b1;
      sconv <= 1'b0;
      val <= lfsr(rnd);
      acc(1'b1, 9'h000, 4'hf, 32'h700);
      idle;
      rdx(9'h004, {16'h0, lfsr(rnd)});
      acc(1'b1, 9'h00c, 4'hf, 32'h0);
      @(posedge mclk_i);
      chk({31'h0, cbusy}, 32'h0);
      acc(1'b1, 9'h000, 4'hf, 32'h0);
      idle;
      smode <= 1'b1;
      acc(1'b1, 9'h00c, 4'hf, 32'h0);
      @(posedge mclk_i);
      chk({31'h0, cbusy}, 32'h0);
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge mclk_i);
      bad_count++;
      report_and_stop;
   end
endmodule
`default_nettype wire
